/* hdl/dpas_pkg.sv */
package dpas_pkg;
  localparam logic [7:0] DPAS_ADDR_CTRL = 8'h85;
  localparam logic [7:0] DPAS_ADDR_MODE = 8'h86;
  localparam logic [7:0] DPAS_ADDR_PTR_LO = 8'h82;
  localparam logic [7:0] DPAS_ADDR_PTR_HI = 8'h83;
  localparam logic [7:0] DPAS_MODE_RESET = 8'h00;
  localparam logic [7:0] DPAS_CTRL_RESET = 8'h00;
  localparam logic [15:0] DPAS_PTR_RESET = 16'h0000;
  localparam int DPAS_SEL_BIT = 0;
  localparam int DPAS_SWAP_BIT = 6;
  localparam int DPAS_MODE1_LSB = 2;
  localparam int DPAS_MODE0_LSB = 0;
  localparam logic [7:0] DPAS_MODE_MASK = 8'h0F;
  localparam logic [7:0] DPAS_CTRL_MASK = 8'h41;
  localparam logic [1:0] DPAS_STEP_NONE = 2'h0;
  localparam logic [1:0] DPAS_STEP_RSVD = 2'h1;
  localparam logic [1:0] DPAS_STEP_INC = 2'h2;
  localparam logic [1:0] DPAS_STEP_DEC = 2'h3;
endpackage : dpas_pkg

/* hdl/dpas_stepper.sv */
module dpas_stepper
  import dpas_pkg::*;
#(
  parameter int PTR_W = 16
) (
  input wire logic [PTR_W-1:0] ptr_in,
  input wire logic [1:0] mode,
  output logic [PTR_W-1:0] ptr_out
);
  // reserved code falls through to no change
  wire logic is_inc = (mode == DPAS_STEP_INC);
  wire logic is_dec = (mode == DPAS_STEP_DEC);
  assign ptr_out = is_inc ? PTR_W'(ptr_in + 1'h1) :
                   is_dec ? PTR_W'(ptr_in - 1'h1) : ptr_in;
endmodule : dpas_stepper

/* hdl/dpas_pointer_unit.sv */
// Operation
// - step used pointer per its mode after move
// - only the active pointer is stepped
// - only external data moves step pointers
// - mode register at 86h, resets 00h
// - bits 3-2 set second pointer mode
// - bits 1-0 set first pointer mode
// - step first, then swap if auto
// - control bit 0 selects active pointer
// - auto swap bit toggles select per move, unless control is written in the same cycle
// - background pointer hidden from sfr access
module dpas_pointer_unit
  import dpas_pkg::*;
#(
  parameter int PTR_W = 16
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic external_data_move,
  input wire logic code_memory_read,
  output logic [PTR_W-1:0] active_external_data_space_pointer,
  output logic [7:0] pointer_step_mode,
  output logic pointer_select_bit,
  output logic auto_swap_bit
);
  ////////////////////////////////////////////////////////////////////
  logic [7:0] mode_r;
  logic [7:0] ctrl_r;
  logic [PTR_W-1:0] first_ptr_r;
  logic [PTR_W-1:0] second_ptr_r;
  logic [PTR_W-1:0] first_stepped;
  logic [PTR_W-1:0] second_stepped;

  wire logic sel = ctrl_r[DPAS_SEL_BIT];
  wire logic swap_en = ctrl_r[DPAS_SWAP_BIT];
  wire logic [1:0] first_pointer_mode_field = mode_r[DPAS_MODE0_LSB +: 2];
  wire logic [1:0] second_pointer_mode_field = mode_r[DPAS_MODE1_LSB +: 2];
  wire logic wr_mode = sfr_wr && (sfr_addr == DPAS_ADDR_MODE);
  wire logic wr_ctrl = sfr_wr && (sfr_addr == DPAS_ADDR_CTRL);
  wire logic wr_lo = sfr_wr && (sfr_addr == DPAS_ADDR_PTR_LO);
  wire logic wr_hi = sfr_wr && (sfr_addr == DPAS_ADDR_PTR_HI);
  // code reads never qualify, even if core raises both
  wire logic step = external_data_move && !code_memory_read;
  wire logic [PTR_W-1:0] active_ptr = sel ? second_ptr_r : first_ptr_r;

  dpas_stepper #(.PTR_W(PTR_W)) u_step0 (
    .ptr_in(first_ptr_r),
    .mode(first_pointer_mode_field),
    .ptr_out(first_stepped)
  );
  dpas_stepper #(.PTR_W(PTR_W)) u_step1 (
    .ptr_in(second_ptr_r),
    .mode(second_pointer_mode_field),
    .ptr_out(second_stepped)
  );

  ////////////////////////////////////////////////////////////////////
  // sfr pointer writes land only in the selected pointer
  function automatic logic [PTR_W-1:0] sfr_update(input logic [PTR_W-1:0] p);
    logic [PTR_W-1:0] q;
    q = p;
    if (wr_lo) q[7:0] = sfr_wdata;
    if (wr_hi) q[15:8] = sfr_wdata;
    return q;
  endfunction : sfr_update

  logic [PTR_W-1:0] first_nxt;
  logic [PTR_W-1:0] second_nxt;
  logic [7:0] ctrl_nxt;
  always_comb begin
    first_nxt = first_ptr_r;
    second_nxt = second_ptr_r;
    ctrl_nxt = wr_ctrl ? (sfr_wdata & DPAS_CTRL_MASK) : ctrl_r;
    if (!sel) begin
      first_nxt = sfr_update(first_ptr_r);
    end else begin
      second_nxt = sfr_update(second_ptr_r);
    end
    // a move beats a same-cycle sfr write to the pointer
    if (step && !sel) begin
      first_nxt = first_stepped;
    end else if (step && sel) begin
      second_nxt = second_stepped;
    end
    // toggle uses old select, so the used pointer stepped first
    if (step && swap_en && !wr_ctrl) begin
      ctrl_nxt[DPAS_SEL_BIT] = !sel;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      mode_r <= DPAS_MODE_RESET;
      ctrl_r <= DPAS_CTRL_RESET;
      first_ptr_r <= DPAS_PTR_RESET;
      second_ptr_r <= DPAS_PTR_RESET;
    end else begin
      if (wr_mode) mode_r <= sfr_wdata & DPAS_MODE_MASK;
      ctrl_r <= ctrl_nxt;
      first_ptr_r <= first_nxt;
      second_ptr_r <= second_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  logic [7:0] rdata_nxt;
  always_comb begin
    unique case (sfr_addr)
      DPAS_ADDR_MODE: rdata_nxt = mode_r;
      DPAS_ADDR_CTRL: rdata_nxt = ctrl_r;
      DPAS_ADDR_PTR_LO: rdata_nxt = active_ptr[7:0];
      DPAS_ADDR_PTR_HI: rdata_nxt = active_ptr[15:8];
      default: rdata_nxt = 8'h00;
    endcase
  end
  assign sfr_rdata = sfr_rd ? rdata_nxt : 8'h00;
  assign active_external_data_space_pointer = active_ptr;
  assign pointer_step_mode = mode_r;
  assign pointer_select_bit = sel;
  assign auto_swap_bit = swap_en;

  ////////////////////////////////////////////////////////////////////
  sequence s_move_first;
    external_data_move && !code_memory_read && !sel && !wr_lo && !wr_hi;
  endsequence

  AST_STEP_INC: assert property (@(posedge clk_sys) disable iff (!reset_n)
    s_move_first and first_pointer_mode_field == DPAS_STEP_INC
    |=> first_ptr_r == PTR_W'($past(first_ptr_r) + 1'h1))
    else $error("first pointer did not increment");
  AST_STEP_DEC: assert property (@(posedge clk_sys) disable iff (!reset_n)
    s_move_first and first_pointer_mode_field == DPAS_STEP_DEC
    |=> first_ptr_r == PTR_W'($past(first_ptr_r) - 1'h1))
    else $error("first pointer did not decrement");
  AST_ONLY_ACTIVE: assert property (@(posedge clk_sys) disable iff (!reset_n)
    step && !sel |=> $stable(second_ptr_r))
    else $error("background pointer changed on move");
  AST_NO_CODE_STEP: assert property (@(posedge clk_sys) disable iff (!reset_n)
    code_memory_read && !sfr_wr |=> $stable(first_ptr_r) && $stable(second_ptr_r))
    else $error("code read changed a pointer");
  AST_MODE_RESET: assert property (@(posedge clk_sys)
    $rose(reset_n) |-> mode_r == DPAS_MODE_RESET && !sel)
    else $error("mode or select not cleared by reset");
  AST_SECOND_INC: assert property (@(posedge clk_sys) disable iff (!reset_n)
    step && sel && !wr_lo && !wr_hi && second_pointer_mode_field == DPAS_STEP_INC
    |=> second_ptr_r == PTR_W'($past(second_ptr_r) + 1'h1))
    else $error("second pointer did not increment");
  AST_RSVD_HOLD: assert property (@(posedge clk_sys) disable iff (!reset_n)
    s_move_first and first_pointer_mode_field == DPAS_STEP_RSVD |=> $stable(first_ptr_r))
    else $error("reserved mode moved pointer");
  AST_SWAP: assert property (@(posedge clk_sys) disable iff (!reset_n)
    step && swap_en && !wr_ctrl |=> sel != $past(sel))
    else $error("auto swap missing");
  AST_NO_SWAP: assert property (@(posedge clk_sys) disable iff (!reset_n)
    step && !swap_en && !wr_ctrl |=> $stable(sel))
    else $error("select changed without auto swap");
  AST_HIDDEN: assert property (@(posedge clk_sys) disable iff (!reset_n)
    wr_lo && !sel && !step |=> $stable(second_ptr_r))
    else $error("sfr write reached background pointer");
  AST_UPPER_ZERO: assert property (@(posedge clk_sys) disable iff (!reset_n)
    mode_r[7:4] == 4'h0)
    else $error("mode upper bits not zero");

  ////////////////////////////////////////////////////////////////////
  // a byte write meeting a move is dropped, so these watch the step alone
  sequence s_move_second;
    external_data_move && !code_memory_read && sel && !wr_lo && !wr_hi;
  endsequence

  // a control write in the same cycle owns the select bit
  sequence s_move_swap;
    step && swap_en && !wr_ctrl;
  endsequence

  AST_SECOND_DEC: assert property (@(posedge clk_sys) disable iff (!reset_n)
    s_move_second and second_pointer_mode_field == DPAS_STEP_DEC
    |=> second_ptr_r == PTR_W'($past(second_ptr_r) - 1'h1))
    else $error("second pointer did not decrement");
  AST_SECOND_HOLD: assert property (@(posedge clk_sys) disable iff (!reset_n)
    s_move_second and second_pointer_mode_field == DPAS_STEP_NONE |=> $stable(second_ptr_r))
    else $error("second pointer moved in no change mode");
  AST_FIRST_HOLD: assert property (@(posedge clk_sys) disable iff (!reset_n)
    s_move_first and first_pointer_mode_field == DPAS_STEP_NONE |=> $stable(first_ptr_r))
    else $error("first pointer moved in no change mode");
  AST_SECOND_RSVD: assert property (@(posedge clk_sys) disable iff (!reset_n)
    s_move_second and second_pointer_mode_field == DPAS_STEP_RSVD |=> $stable(second_ptr_r))
    else $error("reserved mode moved second pointer");

  // the background pointer must neither step nor take sfr bytes
  AST_ONLY_ACTIVE_SECOND: assert property (@(posedge clk_sys) disable iff (!reset_n)
    step && sel |=> $stable(first_ptr_r))
    else $error("background first pointer changed on move");
  AST_HIDDEN_SECOND: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (wr_lo || wr_hi) && sel && !step |=> $stable(first_ptr_r))
    else $error("sfr write reached background first pointer");
  AST_PTR_WRITE: assert property (@(posedge clk_sys) disable iff (!reset_n)
    wr_lo && !sel && !step |=> first_ptr_r[7:0] == $past(sfr_wdata))
    else $error("sfr low byte write lost");

  // step then swap, in both directions
  AST_STEP_THEN_SWAP: assert property (@(posedge clk_sys) disable iff (!reset_n)
    s_move_swap and s_move_first and first_pointer_mode_field == DPAS_STEP_INC
    |=> sel && first_ptr_r == PTR_W'($past(first_ptr_r) + 1'h1))
    else $error("first pointer not stepped before swap");
  AST_SWAP_BACK: assert property (@(posedge clk_sys) disable iff (!reset_n)
    s_move_swap and s_move_second and second_pointer_mode_field == DPAS_STEP_INC
    |=> !sel && second_ptr_r == PTR_W'($past(second_ptr_r) + 1'h1))
    else $error("second pointer not stepped before swap");

  // register side
  AST_CTRL_WRITE_WINS: assert property (@(posedge clk_sys) disable iff (!reset_n)
    step && swap_en && wr_ctrl |=> sel == $past(sfr_wdata[DPAS_SEL_BIT]))
    else $error("control write lost to auto swap");
  AST_MODE_WRITE: assert property (@(posedge clk_sys) disable iff (!reset_n)
    wr_mode |=> mode_r == ($past(sfr_wdata) & DPAS_MODE_MASK))
    else $error("mode write not taken");
  AST_CTRL_ZERO: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (ctrl_r & ~DPAS_CTRL_MASK) == 8'h00)
    else $error("control reserved bits not zero");
endmodule : dpas_pointer_unit

/* dv/dpas_core_model.sv */
// core side: issues sfr cycles and pointer moves, one request per clock
module dpas_core_model
  import dpas_pkg::*;
(
  input wire logic clk_sys,
  input wire logic [7:0] sfr_rdata,
  output logic sfr_wr,
  output logic sfr_rd,
  output logic [7:0] sfr_addr,
  output logic [7:0] sfr_wdata,
  output logic external_data_move,
  output logic code_memory_read
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {sfr_wr, sfr_rd, external_data_move, code_memory_read} = 4'h0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
  end
  // called 2 ns after an edge; request taken and read data sampled at the next edge
  // the request stands until the next call, so no signal is driven twice in one step
  task automatic issue(input logic wr, rd, mv, cm, input logic [7:0] a, d, output logic [7:0] q);
    {sfr_wr, sfr_rd, external_data_move, code_memory_read} = {wr, rd, mv, cm};
    sfr_addr = a;
    sfr_wdata = d;
    @(posedge clk_sys);
    q = sfr_rdata;
    #2;
  endtask : issue
  // released bus shows the inverse, so a stale value is never mistaken for a live one
  task automatic release_bus();
    {sfr_wr, sfr_rd, external_data_move, code_memory_read} = 4'h0;
    sfr_addr = ~sfr_addr;
    sfr_wdata = ~sfr_wdata;
  endtask : release_bus
endmodule : dpas_core_model

/* dv/dual_pointer_auto_step_bench.sv */
module dual_pointer_auto_step_bench;
  import dpas_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys, reset_n, sfr_wr, sfr_rd, external_data_move, code_memory_read;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, pointer_step_mode, q, a;
  logic [15:0] active_external_data_space_pointer;
  logic pointer_select_bit, auto_swap_bit;
  logic [31:0] seed = 32'h0000000A;
  int num_errors = 0, n_checks = 0, mode_m = 0, ctrl_m = 0, f, s, old;
  logic w;
  int ptr_m[$] = '{0, 0};
  logic [7:0] addrs[5] = '{8'h82, 8'h83, 8'h85, 8'h86, 8'h87};
  dpas_pointer_unit #(.PTR_W(16)) uut (.clk_sys(clk_sys), .reset_n(reset_n), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .external_data_move(external_data_move), .code_memory_read(code_memory_read),
    .active_external_data_space_pointer(active_external_data_space_pointer), .pointer_step_mode(pointer_step_mode),
    .pointer_select_bit(pointer_select_bit), .auto_swap_bit(auto_swap_bit));
  dpas_core_model core (.clk_sys(clk_sys), .sfr_rdata(sfr_rdata), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .external_data_move(external_data_move), .code_memory_read(code_memory_read));
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs
  task automatic chk(input string name, input logic [15:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      num_errors++;
    end
  endtask : chk
  task automatic check_state();
    s = ctrl_m & 1;
    chk("pointer", active_external_data_space_pointer, 16'(ptr_m[s]));
    chk("mode", 16'(pointer_step_mode), 16'(mode_m));
    chk("select", 16'(pointer_select_bit), 16'(s));
    chk("swap", 16'(auto_swap_bit), 16'((ctrl_m >> 6) & 1));
  endtask : check_state
  task automatic mdl_wr(input logic [7:0] wa, input int d);
    case (wa)
      DPAS_ADDR_PTR_LO: ptr_m[s] = (ptr_m[s] & 32'hFF00) | d;
      DPAS_ADDR_PTR_HI: ptr_m[s] = (ptr_m[s] & 32'h00FF) | (d << 8);
      DPAS_ADDR_CTRL: ctrl_m = d & 32'h41;
      DPAS_ADDR_MODE: mode_m = d & 32'h0F;
      default: ;
    endcase
  endtask : mdl_wr
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    reset_n = 1'b0;
    repeat (16) @(posedge clk_sys);
    #2 reset_n = 1'b1;
    check_state();
    for (int i = 0; i < 2000; i++) begin
      seed = xs(seed);
      a = addrs[seed[10:8] % 5];
      s = ctrl_m & 1;
      if (i == 1000) begin
        // mid-run reset must clear what the random traffic has built up
        core.release_bus();
        reset_n = 1'b0;
        mode_m = 0;
        ctrl_m = 0;
        ptr_m = '{0, 0};
        repeat (3) @(posedge clk_sys);
        #2 reset_n = 1'b1;
        check_state();
      end
      if (seed[2:0] < 3) begin
        w = seed[24];
        core.issue(w, 1'b0, 1'b1, seed[2:0] == 3'h2, a, seed[23:16], q);
        f = (mode_m >> (2 * s)) & 3;
        old = ptr_m[s];
        if (w) mdl_wr(a, seed[23:16]);
        if (seed[2:0] != 3'h2) begin
          // a move beats a same-cycle byte write; reserved and zero codes hold
          if (f == 2) old = (old + 1) % 65536;
          if (f == 3) old = (old + 65535) % 65536;
          ptr_m[s] = old;
          if (ctrl_m[6] && !(w && a == DPAS_ADDR_CTRL)) ctrl_m ^= 1;
        end
      end else if (seed[2:0] < 6) begin
        core.issue(1'b1, 1'b0, 1'b0, 1'b0, a, seed[23:16], q);
        mdl_wr(a, seed[23:16]);
      end else begin
        core.issue(1'b0, 1'b1, 1'b0, 1'b0, a, seed[23:16], q);
        f = a == DPAS_ADDR_PTR_LO ? ptr_m[s] & 32'hFF : a == DPAS_ADDR_PTR_HI ? ptr_m[s] >> 8 :
          a == DPAS_ADDR_CTRL ? ctrl_m : a == DPAS_ADDR_MODE ? mode_m : 0;
        chk("rdata", 16'(q), 16'(f));
      end
      check_state();
    end
    core.release_bus();
    repeat (2) @(posedge clk_sys);
    #2 check_state();
    end_of_test();
  end
endmodule : dual_pointer_auto_step_bench
